// File: hdl/spw_ctrl.sv
// Serial-controlled register logic for a 256-position potentiometer.
// Assumes the SPI host drives sck only while the frame's chip select is low;
// serial-side logic runs on sck, registers live in the core clock domain.
`timescale 1ns/1ns

module spw_ctrl #(
    parameter int unsigned NV_WRITE_CYCLES = spw_pkg::NV_WRITE_CYCLES,
    parameter int unsigned PRESET_COUNT    = 16
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_in,
    input  wire logic         clk_en_in,
    input  wire logic         sck_in,
    input  wire logic         cs_n_in,
    input  wire logic         si_in,
    input  wire logic         hold_n_in,
    input  wire logic         wp_n_in,
    input  wire logic         addr_strap_hi_in,
    input  wire logic         addr_strap_lo_in,
    output logic              so_out,
    output logic              so_oe_out,
    output logic [7:0]        wiper_position_out,
    output logic [255:0]      tap_sel_out,
    output logic              nv_write_busy_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int unsigned BUSY_W = $clog2(NV_WRITE_CYCLES + 1);

    logic                     link_rst;
    spw_pkg::spw_link_state_t lstate_q;
    logic [2:0]               bit_cnt_q;
    logic [6:0]               shift_q;
    logic [7:0]               rx_byte;
    logic                     byte_done;
    logic                     step_ok;
    spw_pkg::spw_frame_t      frame_q;
    logic                     up_tgl_q;
    logic                     dn_tgl_q;
    logic [2:0]               link_s;
    logic [1:0]               strap_s;
    logic                     wip_s;
    logic                     id_match;
    logic                     op_is_read;
    logic                     op_is_write;
    logic                     op_is_xfr;
    logic [3:0]               rx_opcode;
    logic [7:0]               so_sh_q;
    logic                     so_loaded_q;
    logic [7:0]               read_val;
    logic [3:0]               rd_addr;

    logic [7:0]               preset_reg [PRESET_COUNT];
    logic [7:0]               wiper_position_reg_q;
    spw_pkg::spw_core_state_t cstate_q;
    logic [BUSY_W-1:0]        busy_cnt_q;
    logic                     nv_write_busy_q;
    logic [3:0]               core_s;
    logic                     cs_n_s;
    logic                     wp_n_s;
    logic                     up_s;
    logic                     dn_s;
    logic                     cs_n_d1_q;
    logic                     up_d1_q;
    logic                     dn_d1_q;
    logic                     frame_end;
    logic                     step_up;
    logic                     step_dn;
    logic                     nv_allowed;
    logic                     bank0;
    logic [3:0]               frame_addr;

    // ------------------------------------------------------------------
    // Serial clock domain: synchronisers for static straps and busy flag
    // ------------------------------------------------------------------
    spw_sync #(.WIDTH(3)) u_link_sync (
        .clk_in (sck_in),
        .rst_in (rst_in),
        .d_in   ({addr_strap_hi_in, addr_strap_lo_in, nv_write_busy_q}),
        .q_out  (link_s)
    );

    assign {strap_s, wip_s} = link_s;

    // Frame-scoped logic resets while deselected, so each frame starts clean
    assign link_rst  = rst_in | cs_n_in;
    assign rx_byte   = {shift_q, si_in};
    assign byte_done = (bit_cnt_q == 3'h7);
    assign step_ok   = hold_n_in;                                    // Paused edges are ignored
    assign rx_opcode = rx_byte[spw_pkg::OP_MSB:spw_pkg::OP_LSB];
    assign id_match  = (rx_byte[spw_pkg::ID_TYPE_MSB:spw_pkg::ID_TYPE_LSB] == spw_pkg::DEVICE_TYPE_CODE) &&
                       (rx_byte[spw_pkg::ID_STRAP_HI_POS] == strap_s[1]) &&
                       (rx_byte[spw_pkg::ID_STRAP_LO_POS] == strap_s[0]);

    // Opcode classes: read and write from the latched instruction, transfer from the byte being received
    assign op_is_read  = (frame_q.opcode == spw_pkg::OP_RD_WIPER) || (frame_q.opcode == spw_pkg::OP_RD_PRESET) ||
                         (frame_q.opcode == spw_pkg::OP_RD_STATUS);
    assign op_is_write = (frame_q.opcode == spw_pkg::OP_WR_WIPER) || (frame_q.opcode == spw_pkg::OP_WR_PRESET);
    assign op_is_xfr   = (rx_opcode == spw_pkg::OP_XFR_TO_WIPER) || (rx_opcode == spw_pkg::OP_XFR_TO_PRESET);

    // ------------------------------------------------------------------
    // Serial clock domain: byte framing state machine
    // ------------------------------------------------------------------
    always_ff @(posedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            lstate_q  <= spw_pkg::SPW_L_ID;
            bit_cnt_q <= 3'h0;
            shift_q   <= 7'h00;
        end else if (step_ok) begin
            shift_q   <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            case (lstate_q)
                spw_pkg::SPW_L_ID: begin
                    if (byte_done) begin
                        lstate_q <= id_match ? spw_pkg::SPW_L_INSTR : spw_pkg::SPW_L_IGNORE;
                    end
                end
                spw_pkg::SPW_L_INSTR: begin
                    if (byte_done) begin
                        if (rx_opcode == spw_pkg::OP_INC_DEC) begin
                            lstate_q <= spw_pkg::SPW_L_INCDEC;
                        end else if (op_is_xfr) begin
                            lstate_q <= spw_pkg::SPW_L_DONE;
                        end else begin
                            lstate_q <= spw_pkg::SPW_L_DATA;
                        end
                    end
                end
                spw_pkg::SPW_L_DATA: begin
                    if (byte_done) begin
                        lstate_q <= spw_pkg::SPW_L_DONE;
                    end
                end
                spw_pkg::SPW_L_INCDEC: begin
                    lstate_q <= spw_pkg::SPW_L_INCDEC;
                end
                spw_pkg::SPW_L_DONE: begin
                    lstate_q <= spw_pkg::SPW_L_DONE;               // Extra clocks change nothing
                end
                default: begin
                    lstate_q <= spw_pkg::SPW_L_IGNORE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Serial clock domain: frame result and step toggles
    // ------------------------------------------------------------------
    // Not cleared by deselect: the core reads it after select rises,
    // when sck has stopped and every bit is stable.
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            frame_q  <= '0;
            up_tgl_q <= 1'b0;
            dn_tgl_q <= 1'b0;
        end else if (step_ok && !cs_n_in) begin
            if (lstate_q == spw_pkg::SPW_L_ID && bit_cnt_q == 3'h0) begin
                frame_q.complete <= 1'b0;                          // New frame voids the old result
            end
            if (lstate_q == spw_pkg::SPW_L_INSTR && byte_done) begin
                frame_q.opcode   <= rx_opcode;
                frame_q.reg_sel  <= rx_byte[spw_pkg::REG_SEL_HI_POS:spw_pkg::REG_SEL_LO_POS];
                frame_q.bank_sel <= rx_byte[spw_pkg::BANK_SEL_HI_POS:spw_pkg::BANK_SEL_LO_POS];
                frame_q.complete <= op_is_xfr;                     // Two-byte commands end here
            end
            if (lstate_q == spw_pkg::SPW_L_DATA && byte_done && op_is_write) begin
                frame_q.data     <= rx_byte;
                frame_q.complete <= 1'b1;
            end
            if (lstate_q == spw_pkg::SPW_L_INCDEC) begin
                up_tgl_q <= up_tgl_q ^ si_in;
                dn_tgl_q <= dn_tgl_q ^ !si_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial clock domain: read data path
    // ------------------------------------------------------------------
    // Core registers are not changed by read frames, so they are static
    // while they are sampled here; the busy flag comes through a synchroniser.
    assign rd_addr  = {frame_q.bank_sel, frame_q.reg_sel};
    assign read_val = (frame_q.opcode == spw_pkg::OP_RD_WIPER)  ? wiper_position_reg_q :
                      (frame_q.opcode == spw_pkg::OP_RD_PRESET) ? preset_reg[rd_addr] :
                      {7'h00, wip_s};

    always_ff @(negedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            so_sh_q     <= 8'h00;
            so_loaded_q <= 1'b0;
        end else if (step_ok && lstate_q == spw_pkg::SPW_L_DATA && op_is_read) begin
            if (!so_loaded_q) begin
                so_sh_q     <= read_val;
                so_loaded_q <= 1'b1;
            end else begin
                so_sh_q     <= {so_sh_q[6:0], 1'b0};
            end
        end
    end

    // Drive only while a read byte is on the wire and the device is selected
    assign so_out    = so_sh_q[7];
    assign so_oe_out = !cs_n_in && hold_n_in && so_loaded_q &&
                       (lstate_q == spw_pkg::SPW_L_DATA) && op_is_read;

    // ------------------------------------------------------------------
    // Core domain: input synchronisers and event detection
    // ------------------------------------------------------------------
    spw_sync #(.WIDTH(4)) u_core_sync (
        .clk_in (core_clk_in),
        .rst_in (rst_in),
        .d_in   ({cs_n_in, wp_n_in, up_tgl_q, dn_tgl_q}),
        .q_out  (core_s)
    );

    assign {cs_n_s, wp_n_s, up_s, dn_s} = core_s;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_n_d1_q <= 1'b1;
            up_d1_q   <= 1'b0;
            dn_d1_q   <= 1'b0;
        end else if (clk_en_in) begin
            cs_n_d1_q <= cs_n_s;
            up_d1_q   <= up_s;
            dn_d1_q   <= dn_s;
        end
    end

    assign frame_end  = cs_n_s && !cs_n_d1_q && frame_q.complete;
    assign step_up    = up_s ^ up_d1_q;
    assign step_dn    = dn_s ^ dn_d1_q;
    assign bank0      = (frame_q.bank_sel == spw_pkg::DEFAULT_BANK);
    assign frame_addr = {frame_q.bank_sel, frame_q.reg_sel};
    // A second write while one is in flight is dropped, not queued
    assign nv_allowed = wp_n_s && !nv_write_busy_q;

    // ------------------------------------------------------------------
    // Core domain: wiper position register
    // ------------------------------------------------------------------
    // Volatile: no state survives reset, the load state refills it
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cstate_q             <= spw_pkg::SPW_C_LOAD;
            wiper_position_reg_q <= spw_pkg::WIPER_RESET_VAL;
        end else if (clk_en_in) begin
            case (cstate_q)
                spw_pkg::SPW_C_LOAD: begin
                    wiper_position_reg_q <= preset_reg[0];
                    cstate_q             <= spw_pkg::SPW_C_RUN;
                end
                spw_pkg::SPW_C_RUN: begin
                    if (frame_end && frame_q.opcode == spw_pkg::OP_WR_WIPER) begin
                        wiper_position_reg_q <= frame_q.data;
                    end else if (frame_end && frame_q.opcode == spw_pkg::OP_XFR_TO_WIPER && bank0) begin
                        wiper_position_reg_q <= preset_reg[frame_addr];
                    end else if (step_up && !step_dn) begin
                        if (wiper_position_reg_q != spw_pkg::WIPER_MAX) begin
                            wiper_position_reg_q <= wiper_position_reg_q + 8'h01;
                        end
                    end else if (step_dn && !step_up) begin
                        if (wiper_position_reg_q != spw_pkg::WIPER_MIN) begin
                            wiper_position_reg_q <= wiper_position_reg_q - 8'h01;
                        end
                    end
                end
                default: begin
                    cstate_q <= spw_pkg::SPW_C_LOAD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Core domain: preset registers and nonvolatile write timer
    // ------------------------------------------------------------------
    // The new value is visible at once; the busy window models the
    // programming time during which further nonvolatile writes are dropped.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < PRESET_COUNT; i++) begin
                preset_reg[i] <= spw_pkg::PRESET_RESET_VAL;
            end
            busy_cnt_q      <= '0;
            nv_write_busy_q <= 1'b0;
        end else if (clk_en_in) begin
            if (frame_end && nv_allowed && frame_q.opcode == spw_pkg::OP_WR_PRESET) begin
                preset_reg[frame_addr] <= frame_q.data;
                busy_cnt_q             <= BUSY_W'(NV_WRITE_CYCLES - 1);
                nv_write_busy_q        <= 1'b1;
            end else if (frame_end && nv_allowed && bank0 && frame_q.opcode == spw_pkg::OP_XFR_TO_PRESET) begin
                preset_reg[frame_addr] <= wiper_position_reg_q;
                busy_cnt_q             <= BUSY_W'(NV_WRITE_CYCLES - 1);
                nv_write_busy_q        <= 1'b1;
            end else if (nv_write_busy_q) begin
                if (busy_cnt_q == '0) begin
                    nv_write_busy_q <= 1'b0;
                end else begin
                    busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    spw_tap_decode #(.POS_W(8)) u_tap (
        .pos_in      (wiper_position_reg_q),
        .tap_sel_out (tap_sel_out)
    );

    assign wiper_position_out = wiper_position_reg_q;
    assign nv_write_busy_out  = nv_write_busy_q;

endmodule

// File: hdl/spw_pkg.sv
// Shared constants and types for the serial wiper register control block.
// Assumes a 20 MHz core clock and an SPI host that owns the serial clock.
package spw_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ        = 20_000_000;
    localparam int unsigned NV_WRITE_TIME_US   = 10_000;     // 10 ms worst case
    localparam int unsigned NV_WRITE_CYCLES    = (NV_WRITE_TIME_US * (CORE_CLK_HZ / 1_000_000));

    // ------------------------------------------------------------------
    // Identification byte fields
    // ------------------------------------------------------------------
    localparam logic [3:0]  DEVICE_TYPE_CODE   = 4'hA;       // Arbitrary value, not a real part code
    localparam int unsigned ID_TYPE_MSB        = 7;
    localparam int unsigned ID_TYPE_LSB        = 4;
    localparam int unsigned ID_STRAP_HI_POS    = 1;
    localparam int unsigned ID_STRAP_LO_POS    = 0;

    // ------------------------------------------------------------------
    // Instruction byte fields and opcodes
    // ------------------------------------------------------------------
    localparam int unsigned OP_MSB             = 7;
    localparam int unsigned OP_LSB             = 4;
    localparam int unsigned REG_SEL_HI_POS     = 3;
    localparam int unsigned REG_SEL_LO_POS     = 2;
    localparam int unsigned BANK_SEL_HI_POS    = 1;
    localparam int unsigned BANK_SEL_LO_POS    = 0;
    localparam logic [3:0]  OP_RD_WIPER        = 4'h9;
    localparam logic [3:0]  OP_WR_WIPER        = 4'hA;
    localparam logic [3:0]  OP_RD_PRESET       = 4'hB;
    localparam logic [3:0]  OP_WR_PRESET       = 4'hC;
    localparam logic [3:0]  OP_XFR_TO_WIPER    = 4'hD;
    localparam logic [3:0]  OP_XFR_TO_PRESET   = 4'hE;
    localparam logic [3:0]  OP_INC_DEC         = 4'h2;
    localparam logic [3:0]  OP_RD_STATUS       = 4'h5;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0]  PRESET_RESET_VAL   = 8'h00;
    localparam logic [7:0]  WIPER_RESET_VAL    = 8'h00;
    localparam logic [7:0]  WIPER_MAX          = 8'hFF;
    localparam logic [7:0]  WIPER_MIN          = 8'h00;
    localparam logic [1:0]  DEFAULT_BANK       = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SPW_L_ID, SPW_L_INSTR, SPW_L_DATA, SPW_L_INCDEC, SPW_L_DONE, SPW_L_IGNORE
    } spw_link_state_t;

    typedef enum logic [0:0] {
        SPW_C_LOAD, SPW_C_RUN
    } spw_core_state_t;

    // Result of one frame, handed from the serial clock side to the core
    typedef struct packed {
        logic       complete;
        logic [3:0] opcode;
        logic [1:0] reg_sel;
        logic [1:0] bank_sel;
        logic [7:0] data;
    } spw_frame_t;

endpackage

// File: hdl/spw_sync.sv
// Two flip-flop synchroniser, one lane per bit.
// Assumes each input bit is a level or a toggle that stays put for two
// destination clock edges.
`timescale 1ns/1ns
module spw_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule

// File: hdl/spw_tap_decode.sv
// One-hot decoder from wiper position to tap switch enables.
// Assumes a registered position input, so the enables change cleanly.
`timescale 1ns/1ns
module spw_tap_decode #(
    parameter int unsigned POS_W = 8
) (
    input  wire logic [POS_W-1:0]      pos_in,
    output logic      [(1<<POS_W)-1:0] tap_sel_out
);

    // Exactly one switch closed for any position
    genvar i;
    generate
        for (i = 0; i < (1 << POS_W); i++) begin : g_tap
            assign tap_sel_out[i] = (pos_in == POS_W'(i));
        end
    endgenerate

endmodule

// File: testbench/spw_ctrl_asserts.sv
// Port-level checks for the serial wiper control block.
// Assumes binding into spw_ctrl; everything is sampled on the core clock.
`timescale 1ns/1ns
module spw_ctrl_asserts #(parameter int unsigned NV_WRITE_CYCLES = 20) (
    input wire logic         core_clk_in,
    input wire logic         rst_in,
    input wire logic         cs_n_in,
    input wire logic         wp_n_in,
    input wire logic         so_oe_out,
    input wire logic [7:0]   wiper_position_out,
    input wire logic [255:0] tap_sel_out,
    input wire logic         nv_write_busy_out
);
    // Busy run length, counted so the write time is capped without unrolling
    logic [31:0] busy_cnt_q;
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= nv_write_busy_out ? busy_cnt_q + 32'h1 : 32'h0;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // Frame effects land a few cycles after select rises, so the idle check waits six
    // Output may only drive while selected, with select already low four core cycles earlier
    chk_oe_deselect: assert property (so_oe_out |-> !cs_n_in && !$past(cs_n_in, 4)) else $error("so driven early");
    chk_tap_onehot: assert property (tap_sel_out == (256'h1 << wiper_position_out)) else $error("tap bad");
    chk_wp_block: assert property ($rose(nv_write_busy_out) |-> $past(wp_n_in, 2)) else $error("wp write");
    chk_busy_cap: assert property (busy_cnt_q <= NV_WRITE_CYCLES) else $error("busy too long");
    chk_busy_hold: assert property ($rose(nv_write_busy_out) |=> nv_write_busy_out[*8]) else $error("busy short");
    chk_busy_start: assert property ($rose(nv_write_busy_out) |-> cs_n_in && $past(cs_n_in, 2))
        else $error("write began inside frame");
    chk_step_one: assert property (!cs_n_in && $changed(wiper_position_out) |->
        wiper_position_out + 9'h1 == $past(wiper_position_out) || wiper_position_out == $past(wiper_position_out) + 9'h1)
        else $error("step not single");
    chk_wiper_idle: assert property (cs_n_in && $past(cs_n_in, 6) |-> $stable(wiper_position_out))
        else $error("wiper moved while idle");
    cov_busy: cover property ($rose(nv_write_busy_out));
    cov_read: cover property ($rose(so_oe_out));
    cov_top: cover property (wiper_position_out == 8'hFF);
endmodule
bind spw_ctrl spw_ctrl_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
    .core_clk_in        (core_clk_in),
    .rst_in             (rst_in),
    .cs_n_in            (cs_n_in),
    .wp_n_in            (wp_n_in),
    .so_oe_out          (so_oe_out),
    .wiper_position_out (wiper_position_out),
    .tap_sel_out        (tap_sel_out),
    .nv_write_busy_out  (nv_write_busy_out)
);

// File: testbench/spw_host_model.sv
// SPI host model that clocks frames into the wiper control block.
// Assumes the bench calls frame() one at a time.
`timescale 1ns/1ns
module spw_host_model (
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    // Released output reads back the inverse of the host's own bit
    logic so_w;
    assign so_w = so_oe_in ? so_in : ~si_out;
    initial {sck_out, cs_n_out, si_out} = 3'b010;
    // Clock stands still between frames; gap spaces slow step pulses
    task automatic frame(input logic [31:0] bits, input int n, gap, output logic [7:0] rd);
        cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si_out = bits[i];
            #(7 + gap) sck_out = 1'b1;
            rd = {rd[6:0], so_w};
            #8 sck_out = 1'b0;
        end
        #8 cs_n_out = 1'b1;
        #400;
    endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the serial wiper control block.
// Assumes the host model owns the link; core inputs change on falling edges.
`timescale 1ns/1ns
module tb_top;
    localparam logic [7:0] ID_OK = {spw_pkg::DEVICE_TYPE_CODE, 4'h2};
    logic core_clk_in, rst_in, wp_n, sck, cs_n, si, so, so_oe, busy;
    logic [7:0] wiper, rd;
    int failures = 0;
    int num_checks = 0;
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    spw_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));
    spw_ctrl #(.NV_WRITE_CYCLES(20)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .hold_n_in(1'b1), .wp_n_in(wp_n), .addr_strap_hi_in(1'b1),
        .addr_strap_lo_in(1'b0), .so_out(so), .so_oe_out(so_oe), .wiper_position_out(wiper),
        .tap_sel_out(), .nv_write_busy_out(busy));
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) failures++;
        if (got !== exp) $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic summarize;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Writes wait for the store to finish first; reads may overlap it
    task automatic op(input logic [7:0] id, ins, dat, exp, input int n, input logic rs);
        @(negedge core_clk_in);
        repeat (100) if (!rs && busy !== 1'b0) @(negedge core_clk_in);
        ck({7'h0, busy & ~rs}, 8'h00);
        if ((busy & ~rs) !== 1'b0) summarize;
        host.frame({8'h00, id, ins, dat} >> (24 - n), n, n == 19 ? 200 : 0, rd);
        @(negedge core_clk_in);
        ck(rs ? rd : wiper, exp);
    endtask
    initial begin
        {rst_in, wp_n} = 2'b10;
        repeat (12) @(negedge core_clk_in);
        rst_in = 1'b0;
        op(ID_OK, 8'hA0, 8'h5A, 8'h5A, 24, 1'b0);
        op(ID_OK, 8'h90, 8'h00, 8'h5A, 24, 1'b1);
        op(8'h32, 8'hA0, 8'h11, 8'h5A, 24, 1'b0);
        op(8'hA1, 8'hA0, 8'h11, 8'h5A, 24, 1'b0);
        op(ID_OK, 8'hC4, 8'h33, 8'h5A, 24, 1'b0);
        op(ID_OK, 8'hB4, 8'h00, 8'h00, 24, 1'b1);
        @(negedge core_clk_in) wp_n = 1'b1;
        op(ID_OK, 8'hC4, 8'h33, 8'h5A, 24, 1'b0);
        op(ID_OK, {spw_pkg::OP_RD_STATUS, 4'h1}, 8'h00, 8'h01, 24, 1'b1);
        op(ID_OK, 8'hCB, 8'h77, 8'h5A, 24, 1'b0);
        op(ID_OK, 8'hB4, 8'h00, 8'h33, 24, 1'b1);
        op(ID_OK, 8'hBB, 8'h00, 8'h77, 24, 1'b1);
        op(ID_OK, 8'hA0, 8'hFE, 8'hFE, 24, 1'b0);
        op(ID_OK, 8'h20, 8'hC0, 8'hFE, 19, 1'b0);
        op(ID_OK, 8'hD4, 8'h00, 8'h33, 16, 1'b0);
        op(ID_OK, 8'hDB, 8'h00, 8'h33, 16, 1'b0);
        @(negedge core_clk_in) rst_in = 1'b1;
        @(negedge core_clk_in) rst_in = 1'b0;
        @(negedge core_clk_in) ck(wiper, spw_pkg::PRESET_RESET_VAL);
        summarize;
    end
endmodule
